/* File: verilog/sfg_pkg.sv */
// Constants and types of the serial flash write guard and status block
package sfg_pkg;

	// Command opcodes
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_IDENT_READ    = 8'h9F;
	localparam logic [7:0] OP_STATUS_READ   = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
	localparam logic [7:0] OP_PAGE_WRITE    = 8'h02;
	localparam logic [7:0] OP_REGION_CLEAR  = 8'hD8;
	localparam logic [7:0] OP_FULL_CLEAR    = 8'hC7;

	// Status byte field positions
	localparam int BIT_BUSY    = 0;
	localparam int BIT_LATCH   = 1;
	localparam int BIT_PROT_LO = 2;
	localparam int BIT_PROT_HI = 3;
	localparam int BIT_LOCK    = 7;

	// Address bits that pick the sector
	localparam int ADDR_SECTOR_HI = 16;
	localparam int ADDR_SECTOR_LO = 15;

	// Byte and bit counts that close commands, bytes and the identity output
	localparam logic [2:0] BYTES_OPCODE    = 3'h1;
	localparam logic [2:0] BYTES_STATUS_WR = 3'h2;
	localparam logic [2:0] BYTES_ADDR      = 3'h4;
	localparam logic [2:0] BYTES_PAGE_MIN  = 3'h5;
	localparam logic [2:0] BYTES_SAT       = 3'h7;
	localparam logic [2:0] BIT_LAST        = 3'h7;
	localparam logic [4:0] IDENT_BITS      = 5'h18;

	// Non-volatile bits {lock, prot_hi, prot_lo} in delivery state
	localparam logic [2:0] NV_RESET = 3'h0;

	// Self-timed status write cycle
	localparam int CLK_MHZ             = 250;
	localparam int STATUS_WRITE_TIME_NS = 5000000;
	localparam logic [31:0] CNT_ZERO   = 32'h0;
	localparam logic [31:0] CNT_ONE    = 32'h1;

	// Command phase within one selection
	typedef enum logic [2:0] {
		PH_OPCODE = 3'b000,
		PH_INPUT  = 3'b001,
		PH_STATUS = 3'b010,
		PH_IDENT  = 3'b011,
		PH_SKIP   = 3'b100
	} sfg_phase_e;

	// Request handed to the array engine
	typedef enum logic [1:0] {
		AOP_NONE   = 2'b00,
		AOP_PAGE   = 2'b01,
		AOP_REGION = 2'b10,
		AOP_FULL   = 2'b11
	} sfg_array_op_e;

endpackage

/* File: verilog/sfg_top.sv */
// Serial flash command decoder, status byte and write protection
// Summary of operation
// R1 - Write enable command sets write latch
// R2 - Host sends write enable before each write
// R3 - Write disable command clears write latch
// R4 - Latch clears at power-up and write completion
// R5 - Latch commands are one opcode byte only
// R6 - Identity read shifts 24 bits on falling
// R7 - Identity read ignored while cycle runs
// R8 - Host avoids identity read in power-down
// R9 - Deselect ends output, return to standby
// R10 - Status read always allowed, repeats byte
// R11 - Host polls busy before new commands
// R12 - Busy flag high during any cycle
// R13 - Latch clear refuses all write commands
// R14 - Protect bits guard page and region
// R15 - Full clear only when protect bits zero
// R16 - Lock flag plus low pin: hard lock
// R17 - Status write needs exactly one data byte
// R18 - Bits 6..4,1,0 unwritable, 6..4 read zero
// R19 - Status write timed, busy, clears latch
// R20 - Lock flag clear: latch enough to write
// R21 - Lock flag set: pin high needed
// R22 - Hard lock follows last event, pin exits
// R23 - Write commands end on byte boundary
// R24 - Most significant bit first both ways
// R25 - Lock flag kept non-volatile with protect
module sfg_top
#(
	parameter int          STATUS_WRITE_CYCLES =
		(sfg_pkg::STATUS_WRITE_TIME_NS * sfg_pkg::CLK_MHZ + 999) / 1000,
	parameter logic [7:0]  MAKER_CODE          = 8'hA5,
	parameter logic [7:0]  MEMORY_TYPE         = 8'h5A,
	parameter logic [7:0]  MEMORY_CAPACITY     = 8'h3C
)
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   cs_n,
	input  wire logic                   sclk,
	input  wire logic                   data_in,
	output logic                        data_out,
	output logic                        data_out_oe,
	input  wire logic                   lock_n,
	input  wire logic [2:0]             nv_image_in,
	output logic      [2:0]             nv_image_out,
	output logic                        array_start,
	output sfg_pkg::sfg_array_op_e      array_op,
	output logic      [23:0]            array_addr,
	input  wire logic                   array_busy,
	input  wire logic                   array_done
);
	import sfg_pkg::*;

	// MAKER_CODE, MEMORY_TYPE, MEMORY_CAPACITY values are arbitrary
	localparam logic [31:0] TW_CYCLES = STATUS_WRITE_CYCLES[31:0];
	localparam logic [23:0] IDENT_WORD =
		{MAKER_CODE, MEMORY_TYPE, MEMORY_CAPACITY};

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	logic [3:0]     pin_s1;
	logic [3:0]     pin_s2;
	logic [1:0]     pin_s3;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_s1 <= 4'hB;
			pin_s2 <= 4'hB;
			pin_s3 <= 2'h2;
		end
		else
		begin
			pin_s1 <= {cs_n, sclk, data_in, lock_n};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2[3:2];
		end
	end

	wire            cs_s      = pin_s2[3];
	wire            sclk_s    = pin_s2[2];
	wire            din_s     = pin_s2[1];
	wire            lock_n_s  = pin_s2[0];
	wire            sel       = ~cs_s;
	wire            sclk_rise = sel & sclk_s & ~pin_s3[0];
	wire            sclk_fall = sel & ~sclk_s & pin_s3[0];
	wire            cs_rise   = cs_s & ~pin_s3[1];

	////////////////////////////////////////////////////////////////////
	// Status state
	logic           write_latch_flag;
	logic           lock_flag;
	logic           prot_hi;
	logic           prot_lo;
	logic           nv_loaded;
	logic [31:0]    tw_cnt;
	logic [2:0]     nv_pending;
	logic [7:0]     status_byte;
	wire            sw_busy   = tw_cnt != CNT_ZERO;
	wire            busy      = sw_busy | array_busy;        // [R12]
	wire            hard_lock = lock_flag & ~lock_n_s;       // [R16] [R22]

	always_comb
	begin
		status_byte              = 8'h00;                   // [R18]
		status_byte[BIT_BUSY]    = busy;
		status_byte[BIT_LATCH]   = write_latch_flag;
		status_byte[BIT_PROT_LO] = prot_lo;
		status_byte[BIT_PROT_HI] = prot_hi;
		status_byte[BIT_LOCK]    = lock_flag;
	end

	////////////////////////////////////////////////////////////////////
	// Serial shifter and command phase
	sfg_phase_e     phase;
	sfg_phase_e     next_phase;
	logic [2:0]     bit_cnt;
	logic [2:0]     byte_cnt;
	logic [31:0]    in_sr;
	logic [7:0]     opcode;
	logic [23:0]    addr;
	logic [4:0]     out_cnt;

	wire            byte_done   = sclk_rise & (bit_cnt == BIT_LAST);
	wire            opcode_done = byte_done & (phase == PH_OPCODE);
	wire [7:0]      next_opcode = {in_sr[6:0], din_s};      // [R24]
	wire            reading     = (phase == PH_STATUS) | (phase == PH_IDENT);
	wire            out_step    = (phase == PH_STATUS) |
		(out_cnt != IDENT_BITS);
	wire            next_dout   = (phase == PH_STATUS) ?
		status_byte[3'h7 - out_cnt[2:0]] :                   // [R10]
		((out_cnt != IDENT_BITS) ?
			IDENT_WORD[5'h17 - out_cnt] : 1'b0);             // [R6]

	always_comb
	begin
		case (next_opcode)
			OP_STATUS_READ:
				next_phase = PH_STATUS;                      // [R10]
			OP_IDENT_READ:
				next_phase = busy ? PH_SKIP : PH_IDENT;      // [R7]
			default:
				next_phase = PH_INPUT;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase    <= PH_OPCODE;
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			in_sr    <= 32'h0;
			opcode   <= 8'h00;
			addr     <= 24'h0;
		end
		else if (!sel)
		begin
			phase    <= PH_OPCODE;                           // [R9]
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
		end
		else if (sclk_rise)
		begin
			in_sr   <= {in_sr[30:0], din_s};                 // [R24]
			bit_cnt <= bit_cnt + 3'h1;
			if (byte_done && byte_cnt != BYTES_SAT)
				byte_cnt <= byte_cnt + 3'h1;
			if (opcode_done)
			begin
				opcode <= next_opcode;
				phase  <= next_phase;
			end
			if (byte_done && byte_cnt == BYTES_ADDR - 3'h1)
				addr <= {in_sr[22:0], din_s};
		end
	end

	// Output shifter, data changes on falling serial clock
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_cnt     <= 5'h00;
			data_out    <= 1'b0;
			data_out_oe <= 1'b0;
		end
		else if (!sel)
		begin
			out_cnt     <= 5'h00;
			data_out_oe <= 1'b0;                             // [R9]
		end
		else if (sclk_fall && reading)
		begin
			data_out    <= next_dout;                        // [R6]
			data_out_oe <= 1'b1;
			if (out_step)
				out_cnt <= out_cnt + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Command execution at deselect
	wire            aligned   = cs_rise & (bit_cnt == 3'h0);  // [R23]
	wire            is_input  = phase == PH_INPUT;
	wire            exec_write_enable_cmd = aligned & is_input
		& (byte_cnt == BYTES_OPCODE) & (opcode == OP_WRITE_ENABLE); // [R5]
	wire            exec_write_disable_cmd = aligned & is_input
		& (byte_cnt == BYTES_OPCODE) & (opcode == OP_WRITE_DISABLE); // [R5]
	wire            ok_base   = aligned & is_input & write_latch_flag & ~busy
		& nv_loaded;                                         // [R13]
	wire            status_write_cmd_ok   = ok_base & (opcode == OP_STATUS_WRITE)
		& (byte_cnt == BYTES_STATUS_WR)                      // [R17]
		& ~hard_lock;                                        // [R20] [R21]
	wire            prot_hit  =
		({prot_hi, prot_lo} == 2'b11) |
		(prot_hi & ~prot_lo & addr[ADDR_SECTOR_HI]) |
		(~prot_hi & prot_lo & addr[ADDR_SECTOR_HI]
			& addr[ADDR_SECTOR_LO]);                         // [R14]
	wire            start_page   = ok_base & (opcode == OP_PAGE_WRITE)
		& (byte_cnt >= BYTES_PAGE_MIN) & ~prot_hit;          // [R14]
	wire            start_region = ok_base & (opcode == OP_REGION_CLEAR)
		& (byte_cnt == BYTES_ADDR) & ~prot_hit;              // [R14]
	wire            start_full   = ok_base & (opcode == OP_FULL_CLEAR)
		& (byte_cnt == BYTES_OPCODE) & ~prot_hi & ~prot_lo;  // [R15]
	wire            start_any    = start_page | start_region | start_full;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			array_start <= 1'b0;
			array_op    <= AOP_NONE;
			array_addr  <= 24'h0;
		end
		else
		begin
			array_start <= start_any;
			if (start_any)
			begin
				array_addr <= addr;
				array_op   <= start_page ? AOP_PAGE :
					(start_region ? AOP_REGION : AOP_FULL);
			end
		end
	end

	// Write latch, set wins over any clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			write_latch_flag <= 1'b0;                                     // [R4]
		else if (exec_write_enable_cmd)
			write_latch_flag <= 1'b1;                                     // [R1]
		else if (exec_write_disable_cmd)
			write_latch_flag <= 1'b0;                                     // [R3]
		else if (status_write_cmd_ok || array_done)
			write_latch_flag <= 1'b0;                                     // [R4] [R19]
	end

	// Self-timed status write and non-volatile bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tw_cnt     <= CNT_ZERO;
			nv_pending <= NV_RESET;
			nv_loaded  <= 1'b0;
			lock_flag  <= NV_RESET[2];
			prot_hi    <= NV_RESET[1];
			prot_lo    <= NV_RESET[0];
		end
		else
		begin
			if (!nv_loaded)
			begin
				nv_loaded <= 1'b1;
				{lock_flag, prot_hi, prot_lo} <= nv_image_in; // [R25]
			end
			if (status_write_cmd_ok)
			begin
				tw_cnt     <= TW_CYCLES;                     // [R19]
				nv_pending <= {in_sr[BIT_LOCK], in_sr[BIT_PROT_HI],
					in_sr[BIT_PROT_LO]};                     // [R18]
			end
			else if (sw_busy)
			begin
				tw_cnt <= tw_cnt - CNT_ONE;
				if (tw_cnt == CNT_ONE)
					{lock_flag, prot_hi, prot_lo} <= nv_pending; // [R14]
			end
		end
	end

	assign nv_image_out = {lock_flag, prot_hi, prot_lo};     // [R25]

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_status_write_cmd_accept;
		status_write_cmd_ok;
	endsequence
	sequence s_timed_busy;
		(sw_busy && status_byte[BIT_BUSY] && !write_latch_flag) [*8];
	endsequence
	property p_write_enable_cmd_sets;
		exec_write_enable_cmd |=> write_latch_flag && status_byte[BIT_LATCH];
	endproperty
	a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets)              // [R1]
		else $error("write latch not set by write enable");
	property p_write_disable_cmd_clears;
		exec_write_disable_cmd |=> !write_latch_flag;
	endproperty
	a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears)          // [R3]
		else $error("write latch not cleared by write disable");
	property p_status_write_cmd_timed;
		s_status_write_cmd_accept |=> s_timed_busy;
	endproperty
	a_status_write_cmd_timed: assert property (p_status_write_cmd_timed)            // [R19]
		else $error("status write cycle not busy or latch kept");
	property p_no_latch_refuse;
		!write_latch_flag |=> !array_start && !$rose(sw_busy);
	endproperty
	a_no_latch_refuse: assert property (p_no_latch_refuse)  // [R13]
		else $error("write command accepted without latch");
	property p_hard_lock;
		(lock_flag && !lock_n_s) |-> !status_write_cmd_ok;
	endproperty
	a_hard_lock: assert property (p_hard_lock)              // [R16]
		else $error("status write accepted in hard lock");
	property p_full_clear;
		array_start && array_op == AOP_FULL |->
			$past(prot_hi) == 1'b0 && $past(prot_lo) == 1'b0;
	endproperty
	a_full_clear: assert property (p_full_clear)            // [R15]
		else $error("full clear started with protect bits set");
	property p_ident_skip;
		(opcode_done && next_opcode == OP_IDENT_READ && busy)
			|=> phase == PH_SKIP ##1 !data_out_oe;
	endproperty
	a_ident_skip: assert property (p_ident_skip)            // [R7]
		else $error("identity read decoded while busy");
	property p_ident_first;
		(phase == PH_IDENT && sclk_fall && out_cnt == 5'h00)
			|=> data_out == MAKER_CODE[7] && data_out_oe;
	endproperty
	a_ident_first: assert property (p_ident_first)          // [R6]
		else $error("identity output not maker bit 7 first");
	property p_standby;
		cs_rise |=> phase == PH_OPCODE && !data_out_oe;
	endproperty
	a_standby: assert property (p_standby)                  // [R9]
		else $error("device not in standby after deselect");
	property p_reserved;
		status_byte[6:4] == 3'h0 && status_byte[BIT_BUSY] == busy;
	endproperty
	a_reserved: assert property (p_reserved)                // [R18] [R12]
		else $error("status byte reserved or busy bit wrong");

endmodule

/* File: dv/sfg_host.sv */
// Host serial master model that drives command frames on the link pins
module sfg_host
(
	input  wire logic clk,
	output logic      cs_n,
	output logic      sclk,
	output logic      data_in,
	input  wire logic data_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Half link period of 40 ns in 4 ns clocks
	localparam int HALF = 10;

	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		data_in = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One selection: nbits sent MSB first, data_out taken at each rise
	task automatic frame(input logic [47:0] tx, input int nbits,
		output logic [31:0] rx);
		rx = '0;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (HALF) @(posedge clk);
		for (int i = nbits - 1; i >= 0; i--)
		begin
			data_in <= tx[i];
			repeat (HALF) @(posedge clk);
			sclk <= 1'b1;
			@(posedge clk);
			rx = {rx[30:0], data_out};
			repeat (HALF - 1) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		data_in <= ~data_in;
		repeat (HALF) @(posedge clk);
	endtask
endmodule

/* File: dv/sfg_top_bench.sv */
// Self-checking bench of the write guard and status block
module sfg_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sfg_pkg::*;

	localparam int         SWC = 800;
	// Identity bytes: arbitrary values
	localparam logic [7:0] MK  = 8'h3E;
	localparam logic [7:0] TY  = 8'h71;
	localparam logic [7:0] CP  = 8'h12;

	logic          clk;
	logic          rst;
	logic          cs_n;
	logic          sclk;
	logic          data_in;
	logic          data_out;
	logic          data_out_oe;
	logic          lock_n;
	logic [2:0]    nv_image_in;
	logic [2:0]    nv_image_out;
	logic          array_start;
	sfg_array_op_e array_op;
	logic [23:0]   array_addr;
	logic          array_busy;
	logic          array_done;
	logic [31:0]   rx;
	int            miscompares;
	int            tests_run;
	int            starts;
	int            oe_hits;

	sfg_top #(
		.STATUS_WRITE_CYCLES(SWC),
		.MAKER_CODE(MK),
		.MEMORY_TYPE(TY),
		.MEMORY_CAPACITY(CP)
	) u_sfg_top (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.sclk(sclk),
		.data_in(data_in),
		.data_out(data_out),
		.data_out_oe(data_out_oe),
		.lock_n(lock_n),
		.nv_image_in(nv_image_in),
		.nv_image_out(nv_image_out),
		.array_start(array_start),
		.array_op(array_op),
		.array_addr(array_addr),
		.array_busy(array_busy),
		.array_done(array_done)
	);

	sfg_host u_sfg_host (
		.clk(clk),
		.cs_n(cs_n),
		.sclk(sclk),
		.data_in(data_in),
		.data_out(data_out)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (array_start === 1'b1)
			starts++;
		if (data_out_oe === 1'b1)
			oe_hits++;
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cmd(input logic [47:0] tx, input int n);
		u_sfg_host.frame(tx, n, rx);
	endtask

	task automatic status_is(input logic [7:0] exp);
		cmd({OP_STATUS_READ, 8'h00}, 16);
		check("status", {24'h0, rx[7:0]}, {24'h0, exp});
	endtask

	task automatic status_write_cmd(input logic [7:0] d);
		cmd(OP_WRITE_ENABLE, 8);
		cmd({OP_STATUS_WRITE, d}, 16);
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		do
		begin
			cmd({OP_STATUS_READ, 8'h00}, 16);
			k++;
		end
		while (rx[0] !== 1'b0 && k < 40);
		if (k >= 40)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst = 1'b1;
		lock_n = 1'b1;
		nv_image_in = 3'h0;
		array_busy = 1'b0;
		array_done = 1'b0;
		miscompares = 0;
		tests_run = 0;
		starts = 0;
		oe_hits = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		status_is(8'h00);
		cmd(OP_WRITE_ENABLE, 8);
		status_is(8'h02);
		cmd({OP_WRITE_DISABLE, 1'b0}, 9);
		status_is(8'h02);
		cmd(OP_WRITE_DISABLE, 8);
		status_is(8'h00);
		cmd({OP_STATUS_WRITE, 8'h8C}, 16);
		status_is(8'h00);
		cmd(OP_WRITE_ENABLE, 8);
		cmd({OP_STATUS_WRITE, 8'h8C, 8'h00}, 24);
		status_is(8'h02);
		cmd({OP_IDENT_READ, 24'h0}, 32);
		check("ident", {8'h0, rx[23:0]}, {8'h0, MK, TY, CP});
		cmd({OP_IDENT_READ, 12'h0}, 20);
		status_is(8'h02);
		status_write_cmd(8'hFF);
		cmd({OP_STATUS_READ, 16'h0}, 24);
		check("busy", {16'h0, rx[15:0]}, 32'h0101);
		wait_idle();
		check("nv", {29'h0, nv_image_out}, 32'h7);
		status_is(8'h8C);
		@(posedge clk);
		lock_n <= 1'b0;
		status_write_cmd(8'h00);
		status_is(8'h8E);
		cmd(OP_FULL_CLEAR, 8);
		cmd({OP_REGION_CLEAR, 24'h0}, 32);
		check("starts", starts, 0);
		@(posedge clk);
		lock_n <= 1'b1;
		status_write_cmd(8'h00);
		wait_idle();
		status_is(8'h00);
		@(posedge clk);
		lock_n <= 1'b0;
		status_write_cmd(8'h84);
		wait_idle();
		status_is(8'h84);
		status_write_cmd(8'h00);
		status_is(8'h86);
		@(posedge clk);
		lock_n <= 1'b1;
		status_write_cmd(8'h04);
		wait_idle();
		cmd(OP_WRITE_ENABLE, 8);
		cmd({OP_REGION_CLEAR, 24'h018000}, 32);
		check("starts", starts, 0);
		cmd({OP_PAGE_WRITE, 24'h018000, 8'hA5}, 40);
		check("starts", starts, 0);
		cmd({OP_REGION_CLEAR, 24'h010000}, 32);
		check("starts", starts, 1);
		check("op", {30'h0, array_op}, {30'h0, AOP_REGION});
		check("addr", {8'h0, array_addr}, 32'h010000);
		@(posedge clk);
		array_busy <= 1'b1;
		status_is(8'h07);
		oe_hits = 0;
		cmd({OP_IDENT_READ, 24'h0}, 32);
		check("oe", oe_hits, 0);
		@(posedge clk);
		array_busy <= 1'b0;
		array_done <= 1'b1;
		@(posedge clk);
		array_done <= 1'b0;
		status_is(8'h04);
		cmd(OP_WRITE_ENABLE, 8);
		cmd(OP_FULL_CLEAR, 8);
		check("starts", starts, 1);
		status_write_cmd(8'h00);
		wait_idle();
		cmd(OP_WRITE_ENABLE, 8);
		cmd(OP_FULL_CLEAR, 8);
		check("starts", starts, 2);
		check("op", {30'h0, array_op}, {30'h0, AOP_FULL});
		cmd({OP_PAGE_WRITE, 24'h000100}, 32);
		check("starts", starts, 2);
		cmd({OP_PAGE_WRITE, 24'h000100, 8'hA5}, 40);
		check("starts", starts, 3);
		check("op", {30'h0, array_op}, {30'h0, AOP_PAGE});
		check("addr", {8'h0, array_addr}, 32'h000100);
		nv_image_in <= 3'h5;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		check("nv", {29'h0, nv_image_out}, 32'h5);
		status_is(8'h84);
		report_and_stop();
	end
endmodule
